// >>> src/guard_pkg.sv
// Package: timing constants, state encoding and carrier structs of the guard lock controller
package guard_pkg;

   // ---------------------------------------------------------------
   // Clock and time base
   // ---------------------------------------------------------------
   localparam int unsigned CLK_PERIOD_NS = 10;         // 100 MHz system clock
   localparam int unsigned TICK_NS = 1_000_000;        // One millisecond prescaler tick
   localparam int unsigned TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
   localparam int unsigned MS_PER_S = 1000;
   localparam int unsigned S_PER_MIN = 60;

   // ---------------------------------------------------------------
   // Sequence timeouts, in millisecond ticks
   // ---------------------------------------------------------------
   localparam int unsigned TEACH_S = 10;               // Teach-in before power-off request
   localparam int unsigned REQOFF_MIN = 5;             // Wait for supply removal
   localparam int unsigned INHIBIT_MIN = 10;           // Enabling inhibit after new pairing
   localparam int unsigned TEACH_MS = TEACH_S * MS_PER_S;
   localparam int unsigned REQOFF_MS = REQOFF_MIN * S_PER_MIN * MS_PER_S;
   localparam int unsigned INHIBIT_MS = INHIBIT_MIN * S_PER_MIN * MS_PER_S;

   // ---------------------------------------------------------------
   // Indicator flash patterns, in millisecond ticks
   // ---------------------------------------------------------------
   localparam int unsigned SLOW_HZ = 1;
   localparam int unsigned FAST_HZ = 3;
   localparam int unsigned SLOW_HALF_MS = MS_PER_S / (2 * SLOW_HZ);
   localparam int unsigned FAST_PERIOD_MS = MS_PER_S / FAST_HZ;
   localparam int unsigned BRIEF_MS = 50;              // On time of a brief fast flash
   localparam int unsigned RED_SLOT_MS = 200;          // One half of a red pulse
   localparam int unsigned RED_PULSES = 5;             // Actuator fault code
   localparam int unsigned RED_GAP_SLOTS = 5;          // Dark pause between bursts

   // ---------------------------------------------------------------
   // Widths and typed constants
   // ---------------------------------------------------------------
   localparam int unsigned TIMER_W = 20;
   typedef logic [TIMER_W-1:0] timer_t;
   typedef logic [3:0] slot_t;
   typedef logic [1:0] boot_t;
   localparam slot_t RED_PULSE_SLOTS = slot_t'(2 * RED_PULSES);
   localparam slot_t RED_LAST_SLOT = slot_t'(2 * RED_PULSES + RED_GAP_SLOTS - 1);
   localparam boot_t BOOT_CAPTURE = 2'h2;              // Synchroniser output valid
   localparam boot_t BOOT_RUN = 2'h3;                  // Straps captured, sequencer live

   // Sequencer states, Gray coded along the teach path and from confirm to inhibit
   typedef enum logic [2:0] {
      ST_NORMAL = 3'h0,
      ST_TEACH = 3'h1,
      ST_REQOFF = 3'h3,
      ST_ABORT = 3'h2,
      ST_CONFIRM = 3'h6,
      ST_INHIBIT = 3'h7
   } state_e;

   // Live inputs that change during operation
   typedef struct packed {
      logic safety_one;
      logic safety_two;
      logic lock_cmd;
      logic actuator;
      logic code_match;
      logic detent;
   } live_s;

   // Straps and nonvolatile flags read once after power-up
   typedef struct packed {
      logic individually_coded;
      logic one_time;
      logic repeat_teach;
      logic power_to_lock;
      logic open_disables;
      logic nv_paired;
      logic nv_pending;
      logic nv_inhibit;
   } cfg_s;

   typedef struct packed {
      live_s live;
      cfg_s cfg;
   } pins_s;

   typedef struct packed {
      logic green;
      logic yellow;
      logic red;
   } leds_s;

   // Complete register state of the controller
   typedef struct packed {
      pins_s sync1;
      pins_s sync2;
      cfg_s cfg;
      boot_t boot;
      state_e state;
      timer_t ms_div;
      timer_t timer;
      timer_t slow_ms;
      logic slow;
      timer_t fast_ms;
      timer_t red_ms;
      slot_t red_slot;
      logic first_seen;
      logic act_prev;
      logic paired;
      logic fault;
      logic expired;
      logic lock;
      logic out_one;
      logic out_two;
      leds_s leds;
      logic store;
      logic pending;
      logic inhibit;
   } ctl_s;

   localparam ctl_s CTL_RESET = '0;

endpackage : guard_pkg

// >>> src/guard_lock_controller.sv
// Module: solenoid guard lock controller with teach-in, inhibit, lock and indicator logic
`timescale 1ns/100ps
`default_nettype none
// ---------------------------------------------------------------
// ---------------------------------------------------------------
module guard_lock_controller #(
   parameter int unsigned TICK_CYCLES = guard_pkg::TICK_CYCLES, // Clocks per millisecond
   parameter int unsigned TEACH_MS = guard_pkg::TEACH_MS,
   parameter int unsigned REQOFF_MS = guard_pkg::REQOFF_MS,
   parameter int unsigned INHIBIT_MS = guard_pkg::INHIBIT_MS
) (
   input wire logic clk_in,
   input wire logic nrst_in,
   input wire logic safety_input_one_in,
   input wire logic safety_input_two_in,
   input wire logic lock_cmd_in,
   input wire logic actuator_present_in,
   input wire logic code_match_in,
   input wire logic handle_detent_in,
   input wire logic individually_coded_in,
   input wire logic one_time_teach_variant_in,
   input wire logic repeat_teach_variant_in,
   input wire logic power_to_lock_in,
   input wire logic open_disables_in,
   input wire logic nv_paired_in,
   input wire logic nv_pending_in,
   input wire logic nv_inhibit_in,
   output logic lock_out,
   output logic safety_output_one_out,
   output logic safety_output_two_out,
   output logic led_green_out,
   output logic led_yellow_out,
   output logic led_red_out,
   output logic code_store_out,
   output logic code_pending_out,
   output logic inhibit_pending_out
);

   // ---------------------------------------------------------------
   // State and helpers
   // ---------------------------------------------------------------
   guard_pkg::ctl_s q; // Registered state
   guard_pkg::ctl_s d; // Next state

   // Wrapping increment shared by all prescalers
   function automatic guard_pkg::timer_t wrap_inc(input guard_pkg::timer_t c,
                                                   input guard_pkg::timer_t last);
      return (c == last) ? '0 : guard_pkg::timer_t'(c + 1'b1);
   endfunction : wrap_inc

   // ---------------------------------------------------------------
   // Next-state logic
   // ---------------------------------------------------------------
   always_comb begin
      logic ms_tick;
      logic present;
      logic match;
      logic code_ok;
      logic inputs_ok;
      logic lock_req;
      logic arrive;
      logic teach_ok;
      logic locked_now;
      logic fast_on;
      logic red_on;
      ms_tick = 1'b0;
      present = 1'b0;
      match = 1'b0;
      code_ok = 1'b0;
      inputs_ok = 1'b0;
      lock_req = 1'b0;
      arrive = 1'b0;
      teach_ok = 1'b0;
      locked_now = 1'b0;
      fast_on = 1'b0;
      red_on = 1'b0;
      d = q;
      d.store = 1'b0;

      // Two-stage synchronisers; stage one feeds only stage two
      d.sync1.live.safety_one = safety_input_one_in;
      d.sync1.live.safety_two = safety_input_two_in;
      d.sync1.live.lock_cmd = lock_cmd_in;
      d.sync1.live.actuator = actuator_present_in;
      d.sync1.live.code_match = code_match_in;
      d.sync1.live.detent = handle_detent_in;
      d.sync1.cfg.individually_coded = individually_coded_in;
      d.sync1.cfg.one_time = one_time_teach_variant_in;
      d.sync1.cfg.repeat_teach = repeat_teach_variant_in;
      d.sync1.cfg.power_to_lock = power_to_lock_in;
      d.sync1.cfg.open_disables = open_disables_in;
      d.sync1.cfg.nv_paired = nv_paired_in;
      d.sync1.cfg.nv_pending = nv_pending_in;
      d.sync1.cfg.nv_inhibit = nv_inhibit_in;
      d.sync2 = q.sync1;

      ms_tick = (q.ms_div == guard_pkg::timer_t'(TICK_CYCLES - 1));
      d.ms_div = wrap_inc(q.ms_div, guard_pkg::timer_t'(TICK_CYCLES - 1));
      if (ms_tick) begin
         d.slow_ms = wrap_inc(q.slow_ms, guard_pkg::timer_t'(guard_pkg::SLOW_HALF_MS - 1));
         if (q.slow_ms == guard_pkg::timer_t'(guard_pkg::SLOW_HALF_MS - 1)) begin
            d.slow = ~q.slow;
         end
         d.fast_ms = wrap_inc(q.fast_ms, guard_pkg::timer_t'(guard_pkg::FAST_PERIOD_MS - 1));
         d.red_ms = wrap_inc(q.red_ms, guard_pkg::timer_t'(guard_pkg::RED_SLOT_MS - 1));
         if (q.red_ms == guard_pkg::timer_t'(guard_pkg::RED_SLOT_MS - 1)) begin
            d.red_slot = (q.red_slot == guard_pkg::RED_LAST_SLOT) ? '0 :
                         guard_pkg::slot_t'(q.red_slot + 1'b1);
         end
         // Sequence timer saturates rather than wrapping
         if (q.timer != '1) begin
            d.timer = guard_pkg::timer_t'(q.timer + 1'b1);
         end
      end
      fast_on = (q.fast_ms < guard_pkg::timer_t'(guard_pkg::BRIEF_MS));
      // five pulses, then a dark gap
      red_on = (q.red_slot < guard_pkg::RED_PULSE_SLOTS) && (q.red_slot[0] == 1'b0);

      // Derived conditions from synchronised inputs
      present = q.sync2.live.actuator;
      match = q.sync2.live.code_match;
      code_ok = present && match && (!q.cfg.individually_coded || q.paired);
      inputs_ok = q.sync2.live.safety_one && q.sync2.live.safety_two;
      lock_req = q.cfg.power_to_lock ? q.sync2.live.lock_cmd : !q.sync2.live.lock_cmd;
      arrive = present && !q.act_prev;
      // only the first arrival after power-up
      teach_ok = q.cfg.individually_coded && !q.first_seen && arrive && !match &&
                 (!q.paired || (q.cfg.repeat_teach && !q.cfg.one_time));

      if (q.boot != guard_pkg::BOOT_RUN) begin
         // Start-up: wait for synchronisers, then capture straps once
         d.boot = guard_pkg::boot_t'(q.boot + 1'b1);
         if (q.boot == guard_pkg::BOOT_CAPTURE) begin
            d.cfg = q.sync2.cfg;
            d.paired = q.sync2.cfg.nv_paired;
            d.timer = '0;
            if (q.sync2.cfg.nv_pending) begin
               d.state = guard_pkg::ST_CONFIRM;
               d.pending = 1'b1;
            end else if (q.sync2.cfg.nv_inhibit) begin
               d.state = guard_pkg::ST_INHIBIT;
               d.inhibit = 1'b1;
            end
         end
      end else begin
         d.act_prev = present;
         if (present) begin
            d.first_seen = 1'b1;
         end
         // Sequencer
         case (q.state)
            guard_pkg::ST_NORMAL: begin
               if (teach_ok) begin
                  d.state = guard_pkg::ST_TEACH;
                  d.timer = '0;
               end else if (present && !match &&
                            (!q.cfg.individually_coded || q.paired)) begin
                  d.fault = 1'b1;
               end else if (!present) begin
                  // Fault clears once the guard has been opened
                  d.fault = 1'b0;
               end
            end
            guard_pkg::ST_TEACH: begin
               if (!present) begin
                  // Actuator withdrawn early: nothing learned
                  d.state = guard_pkg::ST_NORMAL;
               end else if (q.timer >= guard_pkg::timer_t'(TEACH_MS)) begin
                  d.state = guard_pkg::ST_REQOFF;
                  d.pending = 1'b1;
                  d.timer = '0;
               end
            end
            guard_pkg::ST_REQOFF: begin
               if (q.timer >= guard_pkg::timer_t'(REQOFF_MS)) begin
                  d.state = guard_pkg::ST_ABORT;
                  d.pending = 1'b0;
                  d.fault = 1'b1;
               end
            end
            guard_pkg::ST_ABORT: begin
               // Held until the next power-up
               d.fault = 1'b1;
            end
            guard_pkg::ST_CONFIRM: begin
               if (present && match) begin
                  // new code replaces the old one
                  d.store = 1'b1;
                  d.pending = 1'b0;
                  d.paired = 1'b1;
                  d.timer = '0;
                  if (q.cfg.repeat_teach && !q.cfg.one_time) begin
                     d.state = guard_pkg::ST_INHIBIT;
                     d.inhibit = 1'b1;
                     d.expired = 1'b0;
                  end else begin
                     d.state = guard_pkg::ST_NORMAL;
                  end
               end
            end
            guard_pkg::ST_INHIBIT: begin
               if (q.timer >= guard_pkg::timer_t'(INHIBIT_MS)) begin
                  d.expired = 1'b1;
               end
               if (q.expired && code_ok) begin
                  d.state = guard_pkg::ST_NORMAL;
                  d.inhibit = 1'b0;
               end
            end
            default: begin
               d.state = guard_pkg::ST_NORMAL;
            end
         endcase
      end

      locked_now = code_ok && lock_req && q.sync2.live.detent && !q.fault &&
                   (q.boot == guard_pkg::BOOT_RUN) &&
                   ((q.state == guard_pkg::ST_NORMAL) || (q.state == guard_pkg::ST_INHIBIT));
      d.lock = locked_now;
      // outputs held off outside normal state
      d.out_one = (q.state == guard_pkg::ST_NORMAL) && (q.boot == guard_pkg::BOOT_RUN) &&
                  !q.fault && inputs_ok && (q.cfg.open_disables ? code_ok : locked_now);
      d.out_two = d.out_one;

      // green supply, yellow condition, red error
      case (q.state)
         guard_pkg::ST_NORMAL: begin
            d.leds.green = inputs_ok || q.slow;
            d.leds.yellow = !present ? 1'b0 : (q.lock ? 1'b1 : q.slow);
            d.leds.red = q.fault && red_on;
         end
         guard_pkg::ST_TEACH: begin
            d.leds = '{green: 1'b0, yellow: q.slow, red: 1'b1};
         end
         guard_pkg::ST_REQOFF: begin
            d.leds = '{green: 1'b0, yellow: fast_on, red: 1'b1};
         end
         guard_pkg::ST_ABORT: begin
            d.leds = '{green: 1'b1, yellow: 1'b0, red: red_on};
         end
         guard_pkg::ST_INHIBIT: begin
            d.leds = '{green: q.slow, yellow: 1'b0, red: 1'b0};
         end
         default: begin
            d.leds = '{green: 1'b1, yellow: 1'b0, red: 1'b0};
         end
      endcase
   end

   // ---------------------------------------------------------------
   // State register
   // ---------------------------------------------------------------
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         q <= guard_pkg::CTL_RESET;
      end else begin
         q <= d;
      end
   end

   // Outputs come straight from state flip-flops
   assign lock_out = q.lock;
   assign safety_output_one_out = q.out_one;
   assign safety_output_two_out = q.out_two;
   assign led_green_out = q.leds.green;
   assign led_yellow_out = q.leds.yellow;
   assign led_red_out = q.leds.red;
   assign code_store_out = q.store;
   assign code_pending_out = q.pending;
   assign inhibit_pending_out = q.inhibit;

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!nrst_in);

   AST_STD_NO_TEACH: assert property (
      (q.boot == guard_pkg::BOOT_RUN && !q.cfg.individually_coded) |->
      q.state != guard_pkg::ST_TEACH) else $error("teach entered with standard coding");
   AST_TEACH_LEDS: assert property (
      (q.state == guard_pkg::ST_TEACH) |=> (!led_green_out && led_red_out))
      else $error("teach indication wrong");
   AST_REQOFF_STAGED: assert property (
      (q.state == guard_pkg::ST_REQOFF) |-> code_pending_out)
      else $error("power-off request without staged code");
   AST_STORE_CAUSE: assert property (
      code_store_out |-> ($past(q.state) == guard_pkg::ST_CONFIRM && $past(present_q())))
      else $error("code stored without redetection");
   AST_ONE_TIME: assert property (
      (q.cfg.one_time && q.paired && q.state == guard_pkg::ST_NORMAL) |=>
      q.state != guard_pkg::ST_TEACH) else $error("one-time variant taught again");
   AST_INHIBIT_OFF: assert property (
      (q.state == guard_pkg::ST_INHIBIT) |->
      (!safety_output_one_out && !safety_output_two_out)[*2])
      else $error("outputs enabled during inhibit");
   AST_DETENT: assert property (
      !q.sync2.live.detent |=> !lock_out) else $error("locked between detents");
   AST_UNLOCK_DROPS: assert property (
      (!q.cfg.open_disables && !lock_out) |-> !safety_output_one_out && !safety_output_two_out)
      else $error("outputs on while unlocked");
   AST_NO_INPUT: assert property (
      (q.state == guard_pkg::ST_NORMAL && !q.fault && !q.sync2.live.safety_one) |=> !led_red_out)
      else $error("red on with missing input");
   AST_FAULT_OFF: assert property (
      q.fault |=> !safety_output_one_out && !safety_output_two_out)
      else $error("outputs on during actuator fault");

   // Helper for assertions: synchronised actuator presence with matching code
   function automatic logic present_q();
      return q.sync2.live.actuator && q.sync2.live.code_match;
   endfunction : present_q

endmodule : guard_lock_controller
`default_nettype wire

// >>> testbench/safety_monitor.sv
// Partner: upstream safety chain and dual-channel monitor facing the guard lock controller
`timescale 1ns/100ps
`default_nettype none
module safety_monitor (
   input wire logic clk_in,
   input wire logic upstream_open_in, // Guard further up the chain is open
   input wire logic output_one_in,
   input wire logic output_two_in,
   output logic safety_one_out = 1'b1, // Chain starts closed
   output logic safety_two_out = 1'b1,
   output logic split_out = 1'b0 // Channels were seen to disagree
);
   // ---------------------------------------------------------------
   // Chain levels and discrepancy latch
   // ---------------------------------------------------------------
   // Both channels follow the upstream guard one clock later, as a real chain would
   always @(posedge clk_in) begin
      safety_one_out <= ~upstream_open_in;
      safety_two_out <= ~upstream_open_in;
      // A real monitor trips on any channel mismatch, so it is latched for good
      if (output_one_in !== output_two_in) begin
         split_out <= 1'b1;
      end
   end
endmodule : safety_monitor
`default_nettype wire

// >>> testbench/guard_lock_controller_bench.sv
// Bench: self-checking run of the guard lock controller against a behavioural model
`timescale 1ns/100ps
`default_nettype none
module guard_lock_controller_bench;
   // ---------------------------------------------------------------
   // Stimulus, observed outputs and counters
   // ---------------------------------------------------------------
   logic clk_in = 1'b0;
   logic nrst_in = 1'b0;
   logic upstream_open = 1'b0; // Opens a guard further up the chain
   logic lock_cmd = 1'b0;
   logic act = 1'b0;
   logic match = 1'b0;
   logic detent = 1'b1;
   logic [7:0] straps = 8'h00; // Coding, variant and nonvolatile straps
   logic s_one, s_two, lock_q, y_one, y_two, grn, yel, red, store, pend, inh, split;
   int fail_count = 0;
   int checks_done = 0;
   int seed = 32'h99EC;
   int n;
   // Short timing parameters keep the run brief; flash lengths stay in ms ticks
   always #5 clk_in = ~clk_in;
   guard_lock_controller #(.TICK_CYCLES(10), .TEACH_MS(20), .REQOFF_MS(40), .INHIBIT_MS(30)) uut (
      .clk_in(clk_in), .nrst_in(nrst_in), .safety_input_one_in(s_one),
      .safety_input_two_in(s_two), .lock_cmd_in(lock_cmd), .actuator_present_in(act),
      .code_match_in(match), .handle_detent_in(detent), .individually_coded_in(straps[7]),
      .one_time_teach_variant_in(straps[6]), .repeat_teach_variant_in(straps[5]),
      .power_to_lock_in(straps[4]), .open_disables_in(straps[3]), .nv_paired_in(straps[2]),
      .nv_pending_in(straps[1]), .nv_inhibit_in(straps[0]), .lock_out(lock_q),
      .safety_output_one_out(y_one), .safety_output_two_out(y_two), .led_green_out(grn),
      .led_yellow_out(yel), .led_red_out(red), .code_store_out(store),
      .code_pending_out(pend), .inhibit_pending_out(inh));
   safety_monitor mon (.clk_in(clk_in), .upstream_open_in(upstream_open),
      .output_one_in(y_one), .output_two_in(y_two), .safety_one_out(s_one),
      .safety_two_out(s_two), .split_out(split));
   // ---------------------------------------------------------------
   // Shared tasks and model
   // ---------------------------------------------------------------
   task automatic chk(input string what, input logic seen, input logic want);
      checks_done++;
      if (seen !== want) begin
         $display("unexpected %s: expected %b, seen %b", what, want, seen);
         fail_count++;
      end
   endtask : chk
   // Sample just after the edge so its updates have landed
   task automatic settle(input int cycles);
      repeat (cycles) @(posedge clk_in);
      #1;
   endtask : settle
   task automatic set_in(input logic a, input logic m, input logic c, input logic d);
      @(posedge clk_in);
      act <= a;
      match <= m;
      lock_cmd <= c;
      detent <= d;
   endtask : set_in
   // Power cycle: straps settle while reset is held, so they are captured cleanly
   task automatic boot(input logic [7:0] cfg);
      set_in(1'b0, 1'b0, 1'b0, 1'b1);
      upstream_open <= 1'b0;
      straps <= cfg;
      nrst_in <= 1'b0;
      settle(1);
      @(posedge clk_in);
      nrst_in <= 1'b1;
      settle(6);
   endtask : boot
   // Lock is granted only with a good code, a detent and the command in lock sense
   function automatic int want_lock(input int ptl, input int c, input int d);
      return d * ((ptl != 0) ? c : 1 - c);
   endfunction : want_lock
   task automatic lock_run(input int ptl, input int od);
      int c, d, u, lk;
      for (int i = 0; i < 12; i++) begin
         c = $random(seed) & 1;
         d = ($random(seed) & 3) != 0;
         u = ($random(seed) & 3) == 0;
         @(posedge clk_in);
         lock_cmd <= c[0];
         detent <= d[0];
         upstream_open <= u[0];
         settle(6);
         lk = want_lock(ptl, c, d);
         chk("lock", lock_q, lk[0]);
         chk("output one", y_one, logic'(u == 0 && (od != 0 || lk != 0)));
         chk("output two", y_two, logic'(u == 0 && (od != 0 || lk != 0)));
         chk("red", red, 1'b0);
         if (lk != 0) chk("yellow locked", yel, 1'b1);
      end
   endtask : lock_run
   // Red code must both light and go dark within 14000 cycles, seven 200 ms slots
   task automatic red_code();
      n = 0;
      repeat (14000) begin
         @(posedge clk_in);
         #1;
         n += red;
      end
      chk("red pulses", logic'(n > 0 && n < 14000), 1'b1);
   endtask : red_code
   task automatic wrap_up();
      if (fail_count == 0 && checks_done > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : wrap_up
   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      boot(8'h00);
      set_in(1'b1, 1'b1, 1'b0, 1'b1);
      lock_run(0, 0);
      boot(8'h18);
      set_in(1'b1, 1'b1, 1'b0, 1'b1);
      lock_run(1, 1);
      set_in(1'b1, 1'b0, 1'b1, 1'b1);
      settle(6);
      chk("fault output", y_one, 1'b0);
      red_code();
      boot(8'hA4);
      set_in(1'b1, 1'b0, 1'b0, 1'b1);
      settle(6);
      chk("teach green", grn, 1'b0);
      chk("teach red", red, 1'b1);
      settle(215);
      chk("request pending", pend, 1'b1);
      settle(420);
      chk("abort pending", pend, 1'b0);
      red_code();
      boot(8'hA2);
      set_in(1'b1, 1'b1, 1'b0, 1'b1);
      n = 0;
      repeat (20) begin
         @(posedge clk_in);
         #1;
         n += store;
      end
      chk("store once", logic'(n == 1), 1'b1);
      chk("staged cleared", pend, 1'b0);
      chk("inhibit on", inh, 1'b1);
      chk("inhibit output", y_one, 1'b0);
      settle(320);
      chk("inhibit over", inh, 1'b0);
      chk("output after", y_one, 1'b1);
      boot(8'hA5);
      set_in(1'b1, 1'b1, 1'b0, 1'b1);
      settle(250);
      chk("restart inhibit", inh, 1'b1);
      chk("restart output", y_one, 1'b0);
      settle(80);
      chk("restart over", inh, 1'b0);
      boot(8'hC4);
      set_in(1'b1, 1'b0, 1'b0, 1'b1);
      settle(215);
      chk("one time pending", pend, 1'b0);
      chk("one time output", y_one, 1'b0);
      chk("channel split", split, 1'b0);
      wrap_up();
   end
   // Whole run is about 30k cycles; this cuts a hang at 60k cycles
   initial begin
      #600_000;
      fail_count++;
      wrap_up();
   end
endmodule : guard_lock_controller_bench
`default_nettype wire
